// ===== rtl/lwc_pkg.sv
// Purpose: Shared constants and types of the wake-up pattern correlator
// Assumes: 25 MHz system clock, slow clock generator made by an enable divider
// Notes:   Register byte offsets are word aligned on APB

package lwc_pkg;

	// System clock and clock generator rates
	localparam int CLK_HZ          = 25_000_000;
	localparam int CLKGEN_HZ_DEF   = 32768;
	localparam int TIMEOUT_STEP_MS = 50;
	localparam int MS_PER_S        = 1000;

	// APB register byte offsets
	localparam int          ADDR_W   = 8;
	localparam logic [7:0]  A_CTRL   = 8'h00;
	localparam logic [7:0]  A_TIMING = 8'h04;
	localparam logic [7:0]  A_PAT1   = 8'h08;
	localparam logic [7:0]  A_PAT2   = 8'h0c;
	localparam logic [7:0]  A_FWC    = 8'h10;
	localparam logic [7:0]  A_STAT   = 8'h14;

	// Control register fields
	localparam int CTRL_COR    = 0;
	localparam int CTRL_DBL    = 1;
	localparam int CTRL_MAN    = 2;
	localparam int CTRL_SYM    = 3;
	localparam int CTRL_ONOFF  = 4;
	localparam int CTRL_SCAN   = 5;
	localparam int CMD_END_BIT = 0;

	// Timing register fields
	localparam int TIM_HALF_LO = 0;
	localparam int TIM_HALF_HI = 4;
	localparam int TIM_TO_LO   = 5;
	localparam int TIM_TO_HI   = 7;

	// Reset values
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] TIMING_RST = 8'h0b;
	localparam logic [7:0] PAT_RST    = 8'h00;

	// Half-bit length: periods are code plus one, codes below 3 clamp
	localparam logic [4:0] HALF_MIN_CODE = 5'h03;
	localparam logic [5:0] HALF_OFFSET   = 6'h01;
	localparam logic [5:0] HALF_MIN      = 6'h04;

	// Protocol limits
	localparam logic [7:0] CARRIER_MAX  = 8'h9b;
	localparam int         PRE_HALVES   = 6;
	localparam logic [5:0] PREAMBLE     = 6'h2a;
	localparam logic [6:0] LIM_SYM16    = 7'h1e;
	localparam logic [6:0] LIM_SYM32    = 7'h2e;
	localparam logic [6:0] SEP_HALVES   = 7'h01;
	localparam logic [2:0] VIOL_TICKS   = 3'h4;
	localparam int         SR_W         = 70;

	// Correlator states
	typedef enum logic [5:0]
	{
		ST_LISTEN  = 6'h01,
		ST_SETTLE  = 6'h02,
		ST_CARRIER = 6'h04,
		ST_PATTERN = 6'h08,
		ST_DELAY   = 6'h10,
		ST_WAKE    = 6'h20
	} lwc_state_t;

endpackage

// ===== rtl/lwc_dec_if.sv
// Purpose: Link between correlator core and Manchester decoder
// Assumes: All signals in the single clock domain
// Notes:   tick is the clock generator enable pulse

`timescale 1ns/10ps

interface lwc_dec_if;
	logic       tick;
	logic       slicer;
	logic       enable;
	logic [5:0] half_len;
	logic       data;
	logic       rclk;
	logic       viol;

	modport core
	(
		output tick, slicer, enable, half_len,
		input  data, rclk, viol
	);

	modport dec
	(
		input  tick, slicer, enable, half_len,
		output data, rclk, viol
	);
endinterface

// ===== rtl/lwc_manchester_dec.sv
// Purpose: Manchester decoder with clock recovery and violation flag
// Assumes: Half-bit length given in clock generator ticks
// Notes:   Data changes only while the recovered clock is low

`timescale 1ns/10ps

module lwc_manchester_dec
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Core link
	lwc_dec_if.dec   lk
);
	import lwc_pkg::*;

	typedef struct packed {
		logic [5:0] ph;
		logic       prev_in;
		logic       first;
		logic       have_first;
		logic       locked;
		logic       data;
		logic       rclk;
		logic       clk_pend;
		logic [2:0] vcnt;
		logic       viol;
	} lwc_dec_t;

	lwc_dec_t r;
	lwc_dec_t n;

	// Half-bit phase tracking, pairing and violation pulse
	always_comb
	begin
		logic       edge_seen;
		logic       sample;
		logic       bad;
		logic [5:0] q;
		logic [2:0] vk;
		logic       vv;
		n         = r;
		bad       = 1'b0;
		vk        = 3'h0;
		vv        = 1'b0;
		q         = lk.half_len >> 2;
		edge_seen = lk.tick && (lk.slicer != r.prev_in);
		sample    = lk.tick && (r.ph == (lk.half_len >> 1));
		if (lk.tick)
		begin
			n.prev_in = lk.slicer;
			// Edges away from a half-bit boundary break the timing
			if (edge_seen)
			begin
				bad  = (r.ph > q) && (r.ph < lk.half_len - q);
				n.ph = '0;
			end
			else
				n.ph = (r.ph == lk.half_len - 6'h01) ? 6'h00 : r.ph + 6'h01;
			if (r.vcnt != 3'h0)
			begin
				n.vcnt = r.vcnt - 3'h1;
				n.viol = (r.vcnt != 3'h1);
			end
			// Clock rises one tick after data settled
			if (r.clk_pend && !sample)
			begin
				n.rclk     = 1'b1;
				n.clk_pend = 1'b0;
			end
		end
		if (sample)
		begin
			n.rclk = 1'b0;
			if (r.have_first && (r.first != lk.slicer))
			begin
				n.data       = r.first;
				n.clk_pend   = 1'b1;
				n.have_first = 1'b0;
				n.locked     = 1'b1;
			end
			else
			begin
				// Two equal halves: resync on the later one
				bad          = bad | r.have_first;
				n.first      = lk.slicer;
				n.have_first = 1'b1;
			end
		end
		// Countdown survives a disable so the flag never comes out short
		vk = n.vcnt;
		vv = n.viol;
		// Only a locked decoder reports; idle line and carrier carry no symbols
		if (bad)
		begin
			n.locked = 1'b0;
			if (r.locked)
			begin
				n.vcnt = VIOL_TICKS;
				n.viol = 1'b1;
			end
		end
		// Disabled decoder keeps data and clock low
		if (!lk.enable)
		begin
			n         = '0;
			n.prev_in = lk.slicer;
			n.vcnt    = vk;
			n.viol    = vv;
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			r <= '0;
		else
			r <= n;
	end

	// Outputs straight from state
	assign lk.data = r.data;
	assign lk.rclk = r.rclk;
	assign lk.viol = r.viol;

endmodule // lwc_manchester_dec

// ===== rtl/lwc_correlator.sv
// Purpose: Wake-up protocol correlator with APB registers
// Assumes: Front-end inputs synchronous to clock; slow clock is an enable
// Notes:   One APB wait state on every access

`timescale 1ns/10ps

// Behaviour
// - Codes 17..31 give 18..32 periods per half-bit
// - Codes 3..16 give 4..17 periods
// - Symbol mode picks 16 or 32 half-bits
// - End-alert command leaves the wake state
// - Timeout code selects 50 ms steps, 0 off
// - Without correlator, wake on frequency detection once RSSI settled
// - With correlator, wake only after carrier, preamble, pattern
// - Double mode needs two identical pattern copies
// - Alert rises one half-bit after pattern
// - Overlong carrier or preamble counts false
// - Decoder drives data and recovered clock
// - Data stable at recovered clock rise
// - Violation flag high four clock generator periods
// - Failed pattern after detection bumps counter
// - Correlation after detection, bits and timing
module lwc_correlator
#(
	parameter int CLKGEN_HZ     = lwc_pkg::CLKGEN_HZ_DEF,
	parameter int TICK_DIV      = lwc_pkg::CLK_HZ / CLKGEN_HZ,
	parameter int TO_STEP_TICKS = CLKGEN_HZ * lwc_pkg::TIMEOUT_STEP_MS / lwc_pkg::MS_PER_S
)
(
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [lwc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Front end
	input  wire logic                      slicer_bit,
	input  wire logic                      freq_detect,
	input  wire logic                      rssi_settled,
	// Host side outputs
	output logic                           wake_alert,
	output logic                           decoded_bit_out,
	output logic                           recovered_bit_clock,
	output logic                           timing_violation_flag
);
	import lwc_pkg::*;

	typedef struct packed {
		lwc_state_t       st;
		logic [7:0]       ctrl;
		logic [7:0]       timing;
		logic [7:0]       pat1;
		logic [7:0]       pat2;
		logic [7:0]       fwc;
		logic [15:0]      div;
		logic             tick;
		logic             slc_prev;
		logic             fd_prev;
		logic [5:0]       ph;
		logic [SR_W-1:0]  sr;
		logic [6:0]       nh;
		logic [7:0]       carr;
		logic [6:0]       dly;
		logic [15:0]      to;
		logic             wake;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} lwc_main_t;

	localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);
	localparam logic [15:0] TO_STEP  = 16'(TO_STEP_TICKS);

	lwc_main_t r;
	lwc_main_t n;
	lwc_dec_if dif ();

	// Half-bit length in clock generator periods
	function automatic logic [5:0] half_len_of(input logic [4:0] code);
		if (code < HALF_MIN_CODE)
			return HALF_MIN;
		return {1'b0, code} + HALF_OFFSET;
	endfunction

	// Expected half-bit stream of the stored pattern, newest bit lowest
	function automatic logic [63:0] pattern_body(input logic [15:0] p16,
		input logic sym, input logic dbl);
		logic [31:0] p32;
		p32 = '0;
		for (int i = 0; i < 16; i++)
			p32[2*i +: 2] = p16[i] ? 2'b10 : 2'b01;
		case ({sym, dbl})
			2'b00:   return {48'h0, p16};
			2'b01:   return {32'h0, p16, p16};
			2'b10:   return {32'h0, p32};
			2'b11:   return {p32, p32};
			default: return 64'h0;
		endcase
	endfunction

	// Next state of registers, correlator and bus
	always_comb
	begin
		logic [5:0]      half;
		logic [5:0]      q;
		logic [5:0]      mid;
		logic            edge_seen;
		logic            fail;
		logic            end_cmd;
		logic            unmapped;
		logic [6:0]      plen;
		logic [6:0]      lim;
		logic [6:0]      need;
		logic [63:0]     body;
		logic [SR_W-1:0] expv;
		logic [SR_W-1:0] mask;
		logic [SR_W-1:0] sr_new;
		logic [6:0]      nh_new;
		logic [15:0]     to_lim;
		n         = r;
		fail      = 1'b0;
		end_cmd   = 1'b0;
		to_lim    = 16'h0000;
		half      = half_len_of(r.timing[TIM_HALF_HI:TIM_HALF_LO]);
		q         = half >> 2;
		mid       = half >> 1;
		edge_seen = r.tick && (slicer_bit != r.slc_prev);
		sr_new    = {r.sr[SR_W-2:0], slicer_bit};
		nh_new    = r.nh + 7'h01;

		// Pattern size, window and half-bit limit
		plen = r.ctrl[CTRL_SYM] ? 7'h20 : 7'h10;
		need = (r.ctrl[CTRL_DBL] ? (plen << 1) : plen) + 7'(PRE_HALVES);
		lim  = ((r.ctrl[CTRL_SYM] ? LIM_SYM32 : LIM_SYM16) << 1) + SEP_HALVES
			+ (r.ctrl[CTRL_DBL] ? plen : 7'h00);
		body = pattern_body({r.pat1, r.pat2}, r.ctrl[CTRL_SYM], r.ctrl[CTRL_DBL]);
		expv = {6'h00, body} | (SR_W'(PREAMBLE) << (need - 7'(PRE_HALVES)));
		mask = (SR_W'(1) << need) - SR_W'(1);

		// Clock generator enable from the divider
		n.tick = 1'b0;
		if (r.div == DIV_LAST)
		begin
			n.div  = 16'h0000;
			n.tick = 1'b1;
		end
		else
			n.div = r.div + 16'h0001;

		// APB: answer in the second access cycle, write on completion
		unmapped = !(paddr inside {A_CTRL, A_TIMING, A_PAT1, A_PAT2, A_FWC, A_STAT});
		if (psel && penable && !r.pready)
		begin
			n.pready  = 1'b1;
			n.pslverr = unmapped;
			n.prdata  = 32'h0;
			if (!pwrite)
			begin
				case (paddr)
					A_CTRL:   n.prdata = {24'h0, r.ctrl};
					A_TIMING: n.prdata = {24'h0, r.timing};
					A_PAT1:   n.prdata = {24'h0, r.pat1};
					A_PAT2:   n.prdata = {24'h0, r.pat2};
					A_FWC:    n.prdata = {24'h0, r.fwc};
					A_STAT:   n.prdata = {25'h0, r.st, r.wake};
					default:  n.prdata = 32'h0;
				endcase
			end
		end
		else if (r.pready)
		begin
			n.pready  = 1'b0;
			n.pslverr = 1'b0;
			n.prdata  = 32'h0;
			if (psel && penable && pwrite && !unmapped)
			begin
				case (paddr)
					A_CTRL:   n.ctrl   = pwdata[7:0];
					A_TIMING: n.timing = pwdata[7:0];
					A_PAT1:   n.pat1   = pwdata[7:0];
					A_PAT2:   n.pat2   = pwdata[7:0];
					A_STAT:   end_cmd  = pwdata[CMD_END_BIT];
					default:  end_cmd  = 1'b0;
				endcase
			end
		end

		// Wake-up protocol sequencer
		if (r.tick)
			n.slc_prev = slicer_bit;
		n.fd_prev = freq_detect;
		case (r.st)
			ST_LISTEN:
			begin
				n.wake = 1'b0;
				// Correlation starts only on a fresh detection
				if (freq_detect && !r.fd_prev)
				begin
					n.carr = 8'h00;
					n.st   = r.ctrl[CTRL_COR] ? ST_CARRIER : ST_SETTLE;
				end
			end
			ST_SETTLE:
			begin
				if (!freq_detect)
					n.st = ST_LISTEN;
				else if (rssi_settled)
				begin
					n.st   = ST_WAKE;
					n.wake = 1'b1;
					n.to   = 16'h0000;
				end
			end
			ST_CARRIER:
			begin
				if (r.tick)
				begin
					if (slicer_bit)
					begin
						n.carr = r.carr + 8'h01;
						fail   = (r.carr >= CARRIER_MAX);
					end
					else
					begin
						// Carrier end starts the separation half-bit
						n.st = ST_PATTERN;
						n.ph = 6'h00;
						n.nh = 7'h00;
						n.sr = '0;
					end
				end
			end
			ST_PATTERN:
			begin
				if (r.tick)
				begin
					if (edge_seen)
					begin
						fail = (r.ph > q) && (r.ph < half - q);
						n.ph = 6'h00;
					end
					else
						n.ph = (r.ph == half - 6'h01) ? 6'h00 : r.ph + 6'h01;
					// Mid-half-bit sample into the correlation window
					if (r.ph == mid)
					begin
						n.sr = sr_new;
						n.nh = nh_new;
						if ((nh_new >= need) && (((sr_new ^ expv) & mask) == '0))
						begin
							n.st  = ST_DELAY;
							n.dly = 7'h00;
						end
						else if (nh_new > lim)
							fail = 1'b1;
					end
				end
			end
			ST_DELAY:
			begin
				// Rest of the last half-bit, then one more half-bit
				// The sample tick is the last-but-rest tick, hence the minus one
				if (r.tick)
				begin
					n.dly = r.dly + 7'h01;
					if (n.dly >= {1'b0, half} + {1'b0, half - mid} - 7'h01)
					begin
						n.st   = ST_WAKE;
						n.wake = 1'b1;
						n.to   = 16'h0000;
					end
				end
			end
			ST_WAKE:
			begin
				to_lim = 16'(r.timing[TIM_TO_HI:TIM_TO_LO]) * TO_STEP;
				if (end_cmd)
				begin
					n.st   = ST_LISTEN;
					n.wake = 1'b0;
				end
				else if (r.tick && (to_lim != 16'h0000))
				begin
					n.to = r.to + 16'h0001;
					if (n.to >= to_lim)
					begin
						n.st   = ST_LISTEN;
						n.wake = 1'b0;
					end
				end
			end
			default:
			begin
				n.st   = ST_LISTEN;
				n.wake = 1'b0;
			end
		endcase

		// A failed attempt returns to listening and is counted
		if (fail)
		begin
			n.st  = ST_LISTEN;
			n.fwc = r.fwc + 8'h01;
		end
	end

	// State register, synchronous reset
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			r        <= '0;
			r.st     <= ST_LISTEN;
			r.ctrl   <= CTRL_RST;
			r.timing <= TIMING_RST;
			r.pat1   <= PAT_RST;
			r.pat2   <= PAT_RST;
			r.fwc    <= 8'h00;
		end
		else
			r <= n;
	end

	// Decoder link; it shares the half-bit setting and slow tick
	assign dif.tick     = r.tick;
	assign dif.slicer   = slicer_bit;
	assign dif.enable   = r.ctrl[CTRL_MAN];
	assign dif.half_len = half_len_of(r.timing[TIM_HALF_HI:TIM_HALF_LO]);

	lwc_manchester_dec u_dec
	(
		.clock (clock),
		.rst_b (rst_b),
		.lk    (dif)
	);

	// Outputs, all registered
	assign prdata                = r.prdata;
	assign pready                = r.pready;
	assign pslverr               = r.pslverr;
	assign wake_alert            = r.wake;
	assign decoded_bit_out       = dif.data;
	assign recovered_bit_clock   = dif.rclk;
	assign timing_violation_flag = dif.viol;

endmodule // lwc_correlator

// ===== sim/lwc_correlator_asserts.sv
// Purpose: Port-level checks of the wake-up correlator
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Mirrors control writes to learn the enabled features
`timescale 1ns/10ps
module lwc_correlator_asserts
	import lwc_pkg::*;
#(
	parameter int TICK_DIV = 4
)
(
	// Clock and reset
	input wire logic              clock,
	input wire logic              rst_b,
	// APB
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Front end and host outputs
	input wire logic              slicer_bit,
	input wire logic              freq_detect,
	input wire logic              rssi_settled,
	input wire logic              wake_alert,
	input wire logic              decoded_bit_out,
	input wire logic              recovered_bit_clock,
	input wire logic              timing_violation_flag
);
	logic       wr_done;
	logic       end_cmd;
	logic       cor_r;
	logic       fd_seen_r;
	logic [2:0] to_r;
	int         vlen_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Completed writes only; a refused or pending access changes nothing
	assign wr_done = psel && penable && pready && pwrite;
	assign end_cmd = wr_done && paddr == A_STAT && pwdata[CMD_END_BIT];

	// Control mirror, detection history, violation pulse length
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			cor_r     <= 1'b0;
			to_r      <= TIMING_RST[TIM_TO_HI:TIM_TO_LO];
			fd_seen_r <= 1'b0;
			vlen_r    <= 0;
		end
		else
		begin
			if (wr_done && paddr == A_CTRL)
				cor_r <= pwdata[CTRL_COR];
			if (wr_done && paddr == A_TIMING)
				to_r <= pwdata[TIM_TO_HI:TIM_TO_LO];
			if (freq_detect)
				fd_seen_r <= 1'b1;
			else if ($fell(wake_alert))
				fd_seen_r <= 1'b0;
			vlen_r <= timing_violation_flag ? vlen_r + 1 : 0;
		end
	end

	property p_viol_len;
		$fell(timing_violation_flag) |-> vlen_r > 3*TICK_DIV && vlen_r <= 4*TICK_DIV;
	endproperty
	a_viol_len: assert property (p_viol_len)
		else $error("violation pulse length wrong");

	property p_rise_stable;
		$rose(recovered_bit_clock) |-> $stable(decoded_bit_out);
	endproperty
	a_rise_stable: assert property (p_rise_stable)
		else $error("data moved at recovered clock rise");

	property p_data_clk_low;
		$changed(decoded_bit_out) |-> !recovered_bit_clock;
	endproperty
	a_data_clk_low: assert property (p_data_clk_low)
		else $error("data moved while recovered clock high");

	property p_end_alert;
		end_cmd |-> ##[1:2] !wake_alert;
	endproperty
	a_end_alert: assert property (p_end_alert)
		else $error("alert not cleared by end command");

	property p_no_timeout;
		wake_alert && to_r == 3'h0 && !end_cmd |=> wake_alert;
	endproperty
	a_no_timeout: assert property (p_no_timeout)
		else $error("alert dropped with timeout disabled");

	property p_rssi;
		$rose(wake_alert) && !cor_r |-> $past(rssi_settled);
	endproperty
	a_rssi: assert property (p_rssi)
		else $error("frequency-only wake before settling");

	property p_fd_first;
		$rose(wake_alert) |-> fd_seen_r;
	endproperty
	a_fd_first: assert property (p_fd_first)
		else $error("wake without frequency detection");

	property p_rdy_pulse;
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse)
		else $error("ready longer than one cycle");

	property p_err_rdy;
		pslverr |-> pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy)
		else $error("error without ready");

	c_wake: cover property ($rose(wake_alert));
	c_viol: cover property ($rose(timing_violation_flag));
	c_err: cover property (pslverr);
endmodule // lwc_correlator_asserts

bind lwc_correlator lwc_correlator_asserts #(.TICK_DIV(TICK_DIV)) i_lwc_correlator_asserts (.*);

// ===== sim/lwc_tx_model.sv
// Purpose: Low-frequency transmitter sending wake-up frames
// Assumes: Half-bit and burst lengths given in clock generator ticks
// Notes:   Carrier off reads as slicer low, as an idle ASK line does
`timescale 1ns/10ps
module lwc_tx_model
#(
	parameter int TICK_DIV = 4
)
(
	// Clock
	input wire logic clock,
	// Front-end lines
	output logic     slicer_bit,
	output logic     freq_detect
);
	initial
	begin
		slicer_bit  = 1'b0;
		freq_detect = 1'b0;
	end

	// One level for a whole number of ticks
	task automatic hold(input logic v, input int t);
		slicer_bit <= v;
		repeat (t*TICK_DIV) @(posedge clock);
	endtask

	// Burst, separation half-bit, preamble, then halves oldest first
	task automatic frame(input int carr, input int h, input logic [63:0] p, input int n);
		freq_detect <= 1'b1;
		hold(1'b1, carr);
		hold(1'b0, h);
		for (int i = 0; i < 6; i++)
			hold(~i[0], h);
		for (int i = n - 1; i >= 0; i--)
			hold(p[i], h);
		slicer_bit  <= 1'b0;
		freq_detect <= 1'b0;
	endtask
endmodule // lwc_tx_model

// ===== sim/test_lwc_correlator.sv
// Purpose: Self-checking bench of the wake-up correlator
// Assumes: Clock generator shortened to four system clocks a tick
// Notes:   Alert timing is checked with a two-tick tolerance
`timescale 1ns/10ps
module test_lwc_correlator;
	import lwc_pkg::*;
	localparam int D  = 4;
	localparam int TS = 8;
	localparam int IDLE = 70*4*D;
	logic        clock, rst_b, psel, penable, pwrite, rssi_settled;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, wake_alert, decoded_bit_out;
	logic        recovered_bit_clock, timing_violation_flag, slicer_bit, freq_detect;
	logic        viol_seen;
	logic [7:0]  dec_sr;
	logic [7:0]  ra [5] = '{A_CTRL, A_TIMING, A_PAT1, A_PAT2, A_FWC};
	logic [7:0]  rv [5] = '{CTRL_RST, TIMING_RST, PAT_RST, PAT_RST, 8'h00};
	int          err_count, check_count, cyc;

	lwc_correlator #(.TICK_DIV(D), .TO_STEP_TICKS(TS)) i_lwc_correlator (.*);
	lwc_tx_model #(.TICK_DIV(D)) i_lwc_tx_model (.*);

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Decoded bit history
	always @(posedge recovered_bit_clock)
		dec_sr <= {dec_sr[6:0], decoded_bit_out};

	// Violation history and hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (timing_violation_flag === 1'b1)
			viol_seen = 1'b1;
		if (cyc > 40000)
		begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		check_count++;
		if (g < lo || g > hi)
		begin
			err_count++;
			$display("MISMATCH %s expected %0d to %0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// One APB transfer; waits an edge first so strobes never toggle twice
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1 && cyc < 40000);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// Cycles until the alert reaches a level, bounded; looks at settled values
	task automatic wait_wake(input logic lv, input string nm, input int lo, input int hi);
		int n;
		n = 0;
		@(negedge clock);
		while (wake_alert !== lv && n <= hi)
		begin
			@(negedge clock);
			n++;
		end
		chk_rng(nm, lo, hi, n);
		// Back on the rising edge for the next driver
		@(posedge clock);
	endtask

	function automatic logic [31:0] sym(input logic [15:0] b);
		for (int i = 0; i < 16; i++)
			sym[2*i +: 2] = b[i] ? 2'b10 : 2'b01;
	endfunction

	initial
	begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rssi_settled = 1'b0;
		viol_seen = 1'b0;
		err_count = 0;
		check_count = 0;
		cyc = 0;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		// Reset values, read-only counter, unmapped address
		foreach (ra[i])
			rdchk("reset value", ra[i], rv[i]);
		apb(1'b1, A_FWC, 32'h55);
		rdchk("count read-only", A_FWC, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, err);
		// Single 16-half pattern, shortest half-bit
		apb(1'b1, A_PAT1, 32'ha5);
		apb(1'b1, A_PAT2, 32'h5a);
		apb(1'b1, A_TIMING, 32'h03);
		apb(1'b1, A_CTRL, 32'h05);
		i_lwc_tx_model.frame(20, 4, 64'ha55a, 16);
		wait_wake(1'b1, "alert delay", 2*D, 6*D);
		chk("decoded bits", 32'hc3, dec_sr);
		repeat (100) @(posedge clock);
		chk("alert held", 32'h1, wake_alert);
		apb(1'b1, A_STAT, 32'h1);
		wait_wake(1'b0, "end alert", 0, 2);
		// Wrong pattern with Manchester violations
		viol_seen = 1'b0;
		i_lwc_tx_model.frame(20, 4, 64'hff00, 16);
		repeat (IDLE) @(posedge clock);
		chk("no wake on mismatch", 32'h0, wake_alert);
		rdchk("false count", A_FWC, 32'h1);
		chk("violation seen", 32'h1, viol_seen);
		// Overlong carrier
		i_lwc_tx_model.frame(160, 4, 64'ha55a, 16);
		repeat (IDLE) @(posedge clock);
		chk("no wake on long burst", 32'h0, wake_alert);
		rdchk("false count", A_FWC, 32'h2);
		// Double pattern, then timeout of one step
		apb(1'b1, A_CTRL, 32'h07);
		apb(1'b1, A_TIMING, 32'h23);
		i_lwc_tx_model.frame(20, 4, 64'ha55a, 16);
		repeat (IDLE) @(posedge clock);
		chk("single copy refused", 32'h0, wake_alert);
		rdchk("false count", A_FWC, 32'h3);
		i_lwc_tx_model.frame(20, 4, 64'ha55aa55a, 32);
		wait_wake(1'b1, "double alert", 2*D, 6*D);
		wait_wake(1'b0, "timeout", (TS-2)*D, (TS+2)*D);
		// Symbol mode at the longest-table boundary code
		apb(1'b1, A_CTRL, 32'h09);
		apb(1'b1, A_TIMING, 32'h11);
		i_lwc_tx_model.frame(20, 18, {32'h0, sym(16'ha55a)}, 32);
		wait_wake(1'b1, "symbol alert", 16*D, 20*D);
		apb(1'b1, A_STAT, 32'h1);
		wait_wake(1'b0, "end alert", 0, 2);
		// Frequency detection only
		apb(1'b1, A_CTRL, 32'h00);
		i_lwc_tx_model.frame(20, 4, 64'h0, 0);
		repeat (8*D) @(posedge clock);
		chk("no wake unsettled", 32'h0, wake_alert);
		rssi_settled <= 1'b1;
		i_lwc_tx_model.frame(20, 4, 64'h0, 0);
		chk("frequency wake", 32'h1, wake_alert);
		apb(1'b1, A_STAT, 32'h1);
		wait_wake(1'b0, "end alert", 0, 2);
		print_verdict();
	end
endmodule // test_lwc_correlator
